// >>> hw/cxi_ident.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - ID28..15 packed in bytes zero and one
// - ID14..0 packed in bytes two, three
// - identifier sent msb first
// - smaller identifier wins arbitration
// - receive stores srr as sampled
// - ide zero standard, one extended
// - receive sets ide from frame
// - transmit format follows stored ide
// - receive rtr mirrors frame rtr
// - transmit rtr sets frame type
module cxi_ident
#(
	parameter int unsigned BIT_DIV = cxi_pkg::BIT_DIV
)
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        can_rx,
	output logic             can_tx
);
	if (BIT_DIV < 2 || BIT_DIV > 65535)
	begin : g_div_check
		$error("BIT_DIV out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0]  tx_q [4];
	logic [7:0]  tx_d [4];
	logic [7:0]  rx_q [4];
	logic [7:0]  rx_d [4];
	logic        tx_buffer_empty_flag_q, tx_buffer_empty_flag_d;
	logic        rx_buffer_full_flag_q, rx_buffer_full_flag_d;
	logic        tx_buffer_select_reg_q, tx_buffer_select_reg_d;
	logic        arb_lost_q, arb_lost_d;
	logic [31:0] prdata_q, prdata_d;
	cxi_pkg::cxi_state_t state_q, state_d;
	logic [15:0] div_q, div_d;
	logic [5:0]  cnt_q, cnt_d;
	logic [31:0] shift_q, shift_d;
	logic [5:0]  len_q, len_d;
	logic        can_tx_q, can_tx_d;
	logic [31:0] frame_bits;
	logic [5:0]  frame_len;
	logic        bit_tick;
	logic        wr_acc;
	logic        rd_setup;
	logic        acc_err;
	logic        tx_open;
	logic        ide_pt;
	logic        rx_last;

	function automatic logic [1:0] reg_index(input logic [7:0] a);
		reg_index = a[3:2];
	endfunction

	function automatic logic is_tx_byte(input logic [7:0] a);
		is_tx_byte = (a[7:4] == 4'h0) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic is_rx_byte(input logic [7:0] a);
		is_rx_byte = (a[7:4] == 4'h1) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic is_ctl_word(input logic [7:0] a);
		is_ctl_word = (a == cxi_pkg::ADDR_CTRL) || (a == cxi_pkg::ADDR_STATUS);
	endfunction

	cxi_idpack u_pack
	(
		.b0         (tx_q[cxi_pkg::IDX_IDENT0]),
		.b1         (tx_q[cxi_pkg::IDX_IDENT1]),
		.b2         (tx_q[cxi_pkg::IDX_IDENT2]),
		.b3         (tx_q[cxi_pkg::IDX_IDENT3]),
		.frame_bits (frame_bits),
		.frame_len  (frame_len)
	);

	////////////////////////////////////////////////////////////////////////
	// apb: zero wait states
	assign pready   = 1'b1;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign prdata   = prdata_q;
	assign bit_tick = (div_q == 16'h0000);
	assign can_tx   = can_tx_q;
	assign tx_open  = tx_buffer_empty_flag_q && tx_buffer_select_reg_q;
	assign ide_pt   = (cnt_q == 6'(cxi_pkg::STD_BITS - 2));
	assign rx_last  = (cnt_q == len_q - 6'h02);

	////////////////////////////////////////////////////////////////////////
	// access check, same answer in setup and access phase
	always_comb
	begin
		acc_err = 1'b0;
		if (is_tx_byte(paddr))
			acc_err = !tx_open;
		else if (is_rx_byte(paddr))
			acc_err = pwrite || !rx_buffer_full_flag_q;
		else if (!is_ctl_word(paddr))
			acc_err = 1'b1;
	end

	assign pslverr = psel && penable && acc_err;

	////////////////////////////////////////////////////////////////////////
	// read data loaded at setup so it stands through the access phase
	always_comb
	begin
		prdata_d = prdata_q;
		if (rd_setup && !acc_err)
		begin
			prdata_d = 32'h0000_0000;
			if (is_tx_byte(paddr))
				prdata_d[7:0] = tx_q[reg_index(paddr)];
			else if (is_rx_byte(paddr))
				prdata_d[7:0] = rx_q[reg_index(paddr)];
			else if (paddr == cxi_pkg::ADDR_CTRL)
				prdata_d[cxi_pkg::CTRL_TX_SEL] = tx_buffer_select_reg_q;
			else
			begin
				prdata_d[cxi_pkg::STAT_TX_EMPTY] = tx_buffer_empty_flag_q;
				prdata_d[cxi_pkg::STAT_RX_FULL]  = rx_buffer_full_flag_q;
				prdata_d[cxi_pkg::STAT_BUSY]     = (state_q != cxi_pkg::ST_IDLE);
				prdata_d[cxi_pkg::STAT_ARB_LOST] = arb_lost_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// buffers, flags, serializer
	always_comb
	begin
		tx_d                   = tx_q;
		rx_d                   = rx_q;
		tx_buffer_empty_flag_d = tx_buffer_empty_flag_q;
		rx_buffer_full_flag_d  = rx_buffer_full_flag_q;
		tx_buffer_select_reg_d = tx_buffer_select_reg_q;
		arb_lost_d             = arb_lost_q;
		state_d                = state_q;
		div_d                  = bit_tick ? 16'(BIT_DIV - 1) : div_q - 16'h0001;
		cnt_d                  = cnt_q;
		shift_d                = shift_q;
		len_d                  = len_q;
		can_tx_d               = can_tx_q;

		if (wr_acc && !pslverr)
		begin
			if (is_tx_byte(paddr))
				tx_d[reg_index(paddr)] = pwdata[7:0];
			else if (paddr == cxi_pkg::ADDR_CTRL)
			begin
				tx_buffer_select_reg_d = pwdata[cxi_pkg::CTRL_TX_SEL];
				if (pwdata[cxi_pkg::CTRL_TX_REQ] && tx_buffer_empty_flag_q)
				begin
					tx_buffer_empty_flag_d = 1'b0;
					arb_lost_d             = 1'b0;
				end
				if (pwdata[cxi_pkg::CTRL_RX_REL])
					rx_buffer_full_flag_d = 1'b0;
			end
		end

		unique case (state_q)
			cxi_pkg::ST_IDLE:
			begin
				can_tx_d = 1'b1;
				if (bit_tick && !tx_buffer_empty_flag_q)
				begin
					state_d  = cxi_pkg::ST_SEND;
					shift_d  = frame_bits;
					len_d    = frame_len;
					cnt_d    = 6'h00;
					can_tx_d = frame_bits[31];
				end
				else if (bit_tick && !can_rx && !rx_buffer_full_flag_q)
				begin
					// the start zero is the stream msb, held as the cleared shift
					state_d = cxi_pkg::ST_RECV;
					shift_d = 32'h0000_0000;
					cnt_d   = 6'h00;
					len_d   = 6'(cxi_pkg::STD_BITS);
				end
			end
			cxi_pkg::ST_SEND:
			begin
				if (bit_tick)
				begin
					if (can_tx_q && !can_rx)
					begin
						// dominant zero from a smaller id beats our one
						arb_lost_d             = 1'b1;
						tx_buffer_empty_flag_d = 1'b1;
						state_d                = cxi_pkg::ST_IDLE;
						can_tx_d               = 1'b1;
					end
					else if (cnt_q == len_q - 6'h01)
					begin
						tx_buffer_empty_flag_d = 1'b1;
						state_d                = cxi_pkg::ST_IDLE;
						can_tx_d               = 1'b1;
					end
					else
					begin
						shift_d  = {shift_q[30:0], 1'b0};
						can_tx_d = shift_q[30];
						cnt_d    = cnt_q + 6'h01;
					end
				end
			end
			cxi_pkg::ST_RECV:
			begin
				if (bit_tick)
				begin
					shift_d = {shift_q[30:0], can_rx};
					cnt_d   = cnt_q + 6'h01;
					// ide is the 13th bit of the stream: decides the length
					if (ide_pt && can_rx)
						len_d = 6'(cxi_pkg::EXT_BITS);
					else if (rx_last)
					begin
						state_d               = cxi_pkg::ST_IDLE;
						rx_buffer_full_flag_d = 1'b1;
						if (len_q == 6'(cxi_pkg::EXT_BITS))
						begin
							rx_d[cxi_pkg::IDX_IDENT0] = shift_q[30:23];
							rx_d[cxi_pkg::IDX_IDENT1] = {shift_q[22:20], shift_q[19], 1'b1, shift_q[17:15]};
							rx_d[cxi_pkg::IDX_IDENT2] = shift_q[14:7];
							rx_d[cxi_pkg::IDX_IDENT3] = {shift_q[6:0], can_rx};
						end
						else
						begin
							// standard frame: id10..0, rtr, ide=0
							rx_d[cxi_pkg::IDX_IDENT0] = shift_q[11:4];
							rx_d[cxi_pkg::IDX_IDENT1] = {shift_q[3:1], shift_q[0], 1'b0, 3'b000};
							rx_d[cxi_pkg::IDX_IDENT2] = cxi_pkg::RST_BYTE;
							rx_d[cxi_pkg::IDX_IDENT3] = cxi_pkg::RST_BYTE;
						end
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 4; i++)
			begin
				tx_q[i] <= cxi_pkg::RST_BYTE;
				rx_q[i] <= cxi_pkg::RST_BYTE;
			end
			tx_q[cxi_pkg::IDX_IDENT1] <= cxi_pkg::RST_TX_BYTE1;
			tx_buffer_empty_flag_q    <= 1'b1;
			rx_buffer_full_flag_q     <= 1'b0;
			tx_buffer_select_reg_q    <= 1'b0;
			arb_lost_q                <= 1'b0;
			prdata_q                  <= 32'h0000_0000;
			state_q                   <= cxi_pkg::ST_IDLE;
			div_q                     <= 16'h0000;
			cnt_q                     <= 6'h00;
			shift_q                   <= 32'h0000_0000;
			len_q                     <= 6'h00;
			can_tx_q                  <= 1'b1;
		end
		else
		begin
			tx_q                   <= tx_d;
			rx_q                   <= rx_d;
			tx_buffer_empty_flag_q <= tx_buffer_empty_flag_d;
			rx_buffer_full_flag_q  <= rx_buffer_full_flag_d;
			tx_buffer_select_reg_q <= tx_buffer_select_reg_d;
			arb_lost_q             <= arb_lost_d;
			prdata_q               <= prdata_d;
			state_q                <= state_d;
			div_q                  <= div_d;
			cnt_q                  <= cnt_d;
			shift_q                <= shift_d;
			len_q                  <= len_d;
			can_tx_q               <= can_tx_d;
		end
	end
endmodule // cxi_ident
`default_nettype wire

// >>> hw/cxi_idpack.sv
`timescale 1ns/1ps
`default_nettype none
module cxi_idpack
(
	input  wire logic [7:0]  b0,
	input  wire logic [7:0]  b1,
	input  wire logic [7:0]  b2,
	input  wire logic [7:0]  b3,
	output logic      [31:0] frame_bits,
	output logic      [5:0]  frame_len
);
	// arbitration field, msb first at bit 31
	always_comb
	begin
		if (b1[cxi_pkg::B1_IDE_POS])
		begin
			// id28..18, srr, ide, id17..0, rtr
			frame_bits = {b0, b1[7:5], b1[cxi_pkg::B1_SRR_POS], 1'b1, b1[2:0], b2, b3[7:1],
				b3[cxi_pkg::B3_RTR_POS]};
			frame_len  = 6'(cxi_pkg::EXT_BITS);
		end
		else
		begin
			// id10..0, rtr, ide=0
			frame_bits = {b0, b1[7:5], b1[4], 1'b0, 19'h0_0000};
			frame_len  = 6'(cxi_pkg::STD_BITS);
		end
	end
endmodule // cxi_idpack
`default_nettype wire

// >>> hw/cxi_pkg.sv
`default_nettype none
package cxi_pkg;
	// register indices and byte addresses (tx address = 4 * index, rx address = 0x10 + 4 * index)
	localparam int unsigned IDX_IDENT0     = 0;
	localparam int unsigned IDX_IDENT1     = 1;
	localparam int unsigned IDX_IDENT2     = 2;
	localparam int unsigned IDX_IDENT3     = 3;
	localparam logic [7:0]  ADDR_TX_IDENT0 = 8'h00;
	localparam logic [7:0]  ADDR_TX_IDENT1 = 8'h04;
	localparam logic [7:0]  ADDR_TX_IDENT2 = 8'h08;
	localparam logic [7:0]  ADDR_TX_IDENT3 = 8'h0C;
	localparam logic [7:0]  ADDR_RX_IDENT0 = 8'h10;
	localparam logic [7:0]  ADDR_RX_IDENT1 = 8'h14;
	localparam logic [7:0]  ADDR_RX_IDENT2 = 8'h18;
	localparam logic [7:0]  ADDR_RX_IDENT3 = 8'h1C;
	localparam logic [7:0]  ADDR_CTRL      = 8'h20;
	localparam logic [7:0]  ADDR_STATUS    = 8'h24;
	// ident_byte1 fields
	localparam int unsigned B1_SRR_POS     = 4;
	localparam int unsigned B1_IDE_POS     = 3;
	// ident_byte3 field
	localparam int unsigned B3_RTR_POS     = 0;
	// ctrl / status fields
	localparam int unsigned CTRL_TX_REQ    = 0;
	localparam int unsigned CTRL_TX_SEL    = 1;
	localparam int unsigned CTRL_RX_REL    = 2;
	localparam int unsigned STAT_TX_EMPTY  = 0;
	localparam int unsigned STAT_RX_FULL   = 1;
	localparam int unsigned STAT_BUSY      = 2;
	localparam int unsigned STAT_ARB_LOST  = 3;
	// reset values
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [7:0]  RST_TX_BYTE1   = 8'h18;
	// serializer lengths (identifier + srr/ide/rtr)
	localparam int unsigned STD_BITS       = 13;
	localparam int unsigned EXT_BITS       = 32;
	localparam int unsigned BIT_DIV        = 125;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_RECV = 3'b100
	} cxi_state_t;
endpackage : cxi_pkg
`default_nettype wire

// >>> sim/cxi_ident_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cxi_ident_bench;
	localparam int unsigned BD = 4;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic        sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, frame = '0, prdata, rd, cap;
	logic        pready, pslverr, can_tx, node_tx, busy, er, send = 0, hold_dom = 0;
	logic [5:0]  len = '0;
	logic [28:0] id;
	logic [10:0] sid;
	int          error_cnt = 0, comparisons = 0, cyc = 0;
	wire logic   can_rx = can_tx & node_tx;
	initial forever #4 sys_clk = ~sys_clk;
	cxi_ident #(.BIT_DIV(BD)) DUT (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx));
	cxi_node #(.BIT_DIV(BD)) u_node (.sys_clk(sys_clk), .send(send), .hold_dom(hold_dom),
		.frame(frame), .len(len), .busy(busy), .node_tx(node_tx));
	////////////////////////////////////////////////////////////////
	task summarize;
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			summarize();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		comparisons++;
		if ((got & msk) !== (exp & msk))
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		er = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	task txw(input logic [31:0] b);
		for (int i = 0; i < 4; i++)
			apb(1, 8'(4 * i), 32'(b[31 - 8 * i -: 8]));
	endtask
	task rx4(input logic [31:0] e, input logic [31:0] m);
		for (int i = 0; i < 4; i++)
		begin
			apb(0, 8'(cxi_pkg::ADDR_RX_IDENT0 + 4 * i), '0);
			chk(rd, 32'(e[31 - 8 * i -: 8]), 32'(m[31 - 8 * i -: 8]));
		end
	endtask
	task capture(input int n);
		cap = '0;
		do @(negedge sys_clk); while (can_tx !== 1'b0);
		repeat (BD / 2) @(negedge sys_clk);
		for (int i = 0; i < n; i++)
		begin
			cap = {cap[30:0], can_tx};
			repeat (BD) @(negedge sys_clk);
		end
	endtask
	task node_send(input logic [31:0] f, input logic [5:0] n);
		@(posedge sys_clk);
		frame <= f;
		len <= n;
		send <= 1;
		@(posedge sys_clk);
		send <= 0;
		do @(negedge sys_clk); while (busy);
		repeat (2 * BD) @(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge sys_clk);
		srst <= 0;
		@(posedge sys_clk);
		apb(0, cxi_pkg::ADDR_TX_IDENT1, '0);
		chk(32'(er), ONE, ONE);
		apb(1, cxi_pkg::ADDR_CTRL, 32'h0000_0002);
		apb(0, cxi_pkg::ADDR_TX_IDENT1, '0);
		chk(rd, 32'h0000_0018, 32'h0000_00FF);
		apb(0, cxi_pkg::ADDR_RX_IDENT0, '0);
		chk(32'(er), ONE, ONE);
		apb(1, cxi_pkg::ADDR_RX_IDENT0, 32'h0000_0005);
		chk(32'(er), ONE, ONE);
		apb(0, 8'h30, '0);
		chk(32'(er), ONE, ONE);
		id = 29'hABC_DE12;
		txw({id[28:21], id[20:18], 2'b11, id[17:15], id[14:7], id[6:0], 1'b1});
		fork
			capture(32);
			begin
				apb(1, cxi_pkg::ADDR_CTRL, 32'h0000_0003);
				wait (can_tx === 1'b0);
				@(posedge sys_clk);
				apb(1, cxi_pkg::ADDR_TX_IDENT0, '0);
			end
		join
		chk(32'(er), ONE, ONE);
		chk(cap, {id[28:18], 2'b11, id[17:0], 1'b1}, '1);
		sid = 11'h2A5;
		txw({sid[10:3], sid[2:0], 5'h00, 16'h0000});
		fork
			capture(13);
			apb(1, cxi_pkg::ADDR_CTRL, 32'h0000_0003);
		join
		chk(cap, {19'h0_0000, sid, 2'b00}, 32'h0000_1FFF);
		id = 29'h123_4567;
		node_send({id[28:18], 2'b01, id[17:0], 1'b1}, 6'd32);
		apb(0, cxi_pkg::ADDR_STATUS, '0);
		chk(rd, 32'h0000_0002, 32'h0000_0002);
		rx4({id[28:21], id[20:18], 2'b01, id[17:15], id[14:7], id[6:0], 1'b1}, '1);
		apb(1, cxi_pkg::ADDR_CTRL, 32'h0000_0006);
		sid = 11'h155;
		node_send({sid, 2'b10, 19'h0_0000}, 6'd13);
		rx4({sid[10:3], sid[2:0], 2'b10, 3'b000, 16'h0000}, 32'hFFF8_FFFF);
		apb(1, cxi_pkg::ADDR_CTRL, 32'h0000_0006);
		txw(32'hFFFF_FFFF);
		apb(1, cxi_pkg::ADDR_CTRL, 32'h0000_0003);
		repeat (BD) @(posedge sys_clk);
		hold_dom <= 1;
		repeat (40 * BD) @(posedge sys_clk);
		hold_dom <= 0;
		apb(0, cxi_pkg::ADDR_STATUS, '0);
		chk(rd, 32'h0000_0009, 32'h0000_0009);
		summarize();
	end
endmodule // cxi_ident_bench
`default_nettype wire

// >>> sim/cxi_ident_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cxi_ident_chk
#(
	parameter int unsigned BIT_DIV = 4
)
(
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        can_rx,
	input wire logic        can_tx
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_ready_high: assert property (pready) else $error("pready low");
	a_rst_line: assert property (disable iff (1'b0) srst |=> can_tx && prdata == 32'h0000_0000)
		else $error("reset state wrong");
	a_bit_hold: assert property ($changed(can_tx) |=> $stable(can_tx) [*3])
		else $error("bit shorter than bit time");
	a_arb_yield: assert property ((can_tx && !can_rx) [*4] |=> can_tx [*4])
		else $error("no yield after lost bit");
	a_rx_wr_err: assert property (psel && penable && pwrite && paddr[7:4] == 4'h1 |-> pslverr)
		else $error("rx write not refused");
	a_bad_addr: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
		else $error("unmapped access not refused");
	a_tx_busy_err: assert property (psel && penable && !can_tx && paddr < 8'h10 |-> pslverr)
		else $error("tx access while sending");
	a_rd_hold: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
		else $error("read data moved");
endmodule // cxi_ident_chk
bind cxi_ident cxi_ident_chk #(.BIT_DIV(BIT_DIV)) u_chk (.sys_clk(sys_clk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx));
`default_nettype wire

// >>> sim/cxi_node.sv
`timescale 1ns/1ps
`default_nettype none
module cxi_node
#(
	parameter int unsigned BIT_DIV = 4
)
(
	input  wire logic        sys_clk,
	input  wire logic        send,
	input  wire logic        hold_dom,
	input  wire logic [31:0] frame,
	input  wire logic [5:0]  len,
	output logic             busy,
	output logic             node_tx
);
	logic [31:0] sh_q  = '0;
	logic [5:0]  left_q = '0;
	int          cnt_q = 0;
	assign busy = left_q != 6'h00;
	// dominant wins, msb first, recessive when released
	assign node_tx = hold_dom ? 1'b0 : (busy ? sh_q[31] : 1'b1);
	always @(posedge sys_clk)
	begin
		if (send)
		begin
			sh_q <= frame;
			left_q <= len;
			cnt_q <= 0;
		end
		else if (busy)
		begin
			cnt_q <= (cnt_q == BIT_DIV - 1) ? 0 : cnt_q + 1;
			if (cnt_q == BIT_DIV - 1)
			begin
				sh_q <= sh_q << 1;
				left_q <= left_q - 6'h01;
			end
		end
	end
endmodule // cxi_node
`default_nettype wire
